// >>> hw/mrsm_pin_mux.sv
// receive-side pin mux with shared strap capture and register slave
// assumes the receive core, transmit encoder and Avalon master run on clk_sys
`timescale 1ns/100ps
`include "mrsm_params.svh"
module mrsm_pin_mux
    import mrsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    // avalon-mm slave
    input wire logic [`MRSM_ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWritedata,
    output logic [31:0] avsReaddata,
    output logic avsWaitrequest,
    output logic irq,
    // receive clock pin, sampled
    input wire logic rxClkPin,
    // receive core side
    input wire logic [3:0] rxNibble,
    input wire logic [4:0] rxSymbol,
    input wire logic rxFrameActive,
    input wire logic rxErrDetect,
    // receive data pins, also straps
    input wire logic [3:0] rxdPinIn,
    output logic [3:0] rxdPinOut,
    output logic [3:0] rxdPinOe,
    // receive error / symbol bit 4 pin
    output logic rxErrPinOut,
    output logic rxErrPinOe,
    // interface select strap pin
    input wire logic rmiiStrapPin,
    // shared interrupt / transmit error pin
    input wire logic sharedIrqTxerrPinIn,
    output logic sharedIrqTxerrPinOut,
    output logic sharedIrqTxerrPinOe,
    // transmit encoder side
    input wire logic [4:0] txCodeIn,
    output logic [4:0] txCodeOut,
    // latched straps for the rest of the device
    output mrsm_mode_t modeStrap,
    output logic rmiiMode,
    output logic irqPinSelectStrap
);
    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [6:0] pinAsync;
    logic [6:0] pinSync;
    logic rxClkSync;
    logic [3:0] rxdSync;
    logic rmiiSync;
    logic sharedSync;

    assign pinAsync = {rxClkPin, sharedIrqTxerrPinIn, rmiiStrapPin, rxdPinIn};
    assign rxdSync = pinSync[3:0];
    assign rmiiSync = pinSync[4];
    assign sharedSync = pinSync[5];
    assign rxClkSync = pinSync[6];

    mrsm_sync #(
        .WIDTH(7)
    ) u_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .async(pinAsync),
        .synced(pinSync)
    );

    // -----------------------------------------------------------------
    // strap capture
    // -----------------------------------------------------------------
    mrsm_strap_state_t strapState;
    mrsm_strap_state_t next_strapState;
    logic [2:0] settleCnt;
    logic [2:0] next_settleCnt;
    mrsm_mode_t next_modeStrap;
    logic next_rmiiMode;
    logic next_irqPinSelectStrap;
    logic strapDone;
    logic strapEvent;

    // wait for the synchroniser to fill before trusting the pins
    always_comb begin
        next_strapState = strapState;
        next_settleCnt = settleCnt;
        next_modeStrap = modeStrap;
        next_rmiiMode = rmiiMode;
        next_irqPinSelectStrap = irqPinSelectStrap;
        strapEvent = 1'b0;
        case (strapState)
            STRAP_SETTLE: begin
                if (settleCnt == `MRSM_SETTLE_CYCLES) begin
                    next_strapState = STRAP_CAPTURE;
                end else begin
                    next_settleCnt = settleCnt + 3'h1;
                end
            end
            STRAP_CAPTURE: begin
                next_modeStrap = rxdSync[2:0];
                next_irqPinSelectStrap = rxdSync[3];
                next_rmiiMode = rmiiSync;
                strapEvent = 1'b1;
                next_strapState = STRAP_RUN;
            end
            STRAP_RUN: begin
                next_strapState = STRAP_RUN;
            end
            default: begin
                next_strapState = STRAP_SETTLE;
            end
        endcase
    end

    // captured once; later pin activity never reaches the straps
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            strapState <= STRAP_SETTLE;
            settleCnt <= 3'h0;
            modeStrap <= 3'h0;
            rmiiMode <= 1'b0;
            irqPinSelectStrap <= 1'b1;
        end else begin
            strapState <= next_strapState;
            settleCnt <= next_settleCnt;
            modeStrap <= next_modeStrap;
            rmiiMode <= next_rmiiMode;
            irqPinSelectStrap <= next_irqPinSelectStrap;
        end
    end

    assign strapDone = (strapState == STRAP_RUN);

    // -----------------------------------------------------------------
    // receive pin drive
    // -----------------------------------------------------------------
    logic [1:0] control;
    logic symbolMode;
    logic speed10;
    logic rxClkLast;
    logic rxClkFall;
    logic [3:0] next_rxdPinOut;
    logic next_rxErrPinOut;
    logic [3:0] bitUsed;

    assign symbolMode = control[`MRSM_CTRL_SYMBOL];
    assign speed10 = control[`MRSM_CTRL_SPEED10];
    assign rxClkFall = rxClkLast & ~rxClkSync;

    // update on the falling receive clock so data is steady at its rise
    always_comb begin
        next_rxdPinOut = rxdPinOut;
        next_rxErrPinOut = rxErrPinOut;
        if (!strapDone) begin
            next_rxdPinOut = 4'h0;
            next_rxErrPinOut = 1'b0;
        end else if (rxClkFall) begin
            if (symbolMode) begin
                next_rxdPinOut = rxSymbol[3:0];
                next_rxErrPinOut = rxSymbol[4];
            end else begin
                next_rxdPinOut = rxNibble;
                next_rxErrPinOut = rxFrameActive & rxErrDetect;
            end
            if (rmiiMode) begin
                next_rxdPinOut[3:2] = 2'h0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rxClkLast <= 1'b0;
            rxdPinOut <= 4'h0;
            rxErrPinOut <= 1'b0;
        end else begin
            rxClkLast <= rxClkSync;
            rxdPinOut <= next_rxdPinOut;
            rxErrPinOut <= next_rxErrPinOut;
        end
    end

    // per-bit enables; upper pair released in rmii mode
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_rxdOe
            assign bitUsed[gi] = (gi < 2) ? 1'b1 : ~rmiiMode;
            assign rxdPinOe[gi] = strapDone & bitUsed[gi];
        end
    endgenerate

    // the pin is undriven until strap capture ends; the pull-down in the mac model holds it low
    assign rxErrPinOe = strapDone;

    // -----------------------------------------------------------------
    // shared interrupt / transmit error pin
    // -----------------------------------------------------------------
    logic txErrActive;
    logic [4:0] next_txCodeOut;

    // open-drain style: pull low only while the interrupt is pending
    assign sharedIrqTxerrPinOut = 1'b0;
    assign sharedIrqTxerrPinOe = strapDone & irqPinSelectStrap & irq;

    // the pin is an input only when the strap chose it so
    assign txErrActive = strapDone & ~irqPinSelectStrap & sharedSync;

    // synced pin adds two cycles of latency against the encoder word
    always_comb begin
        next_txCodeOut = txCodeIn;
        if (strapDone && !irqPinSelectStrap && symbolMode) begin
            next_txCodeOut = {sharedSync, txCodeIn[3:0]};
        end else if (txErrActive && !speed10) begin
            next_txCodeOut = `MRSM_TX_ERROR_GROUP;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            txCodeOut <= 5'h00;
        end else begin
            txCodeOut <= next_txCodeOut;
        end
    end

    // -----------------------------------------------------------------
    // register slave and interrupt
    // -----------------------------------------------------------------
    logic ack;
    logic next_ack;
    logic [`MRSM_EVT_W-1:0] status;
    logic [`MRSM_EVT_W-1:0] next_status;
    logic [`MRSM_EVT_W-1:0] mask;
    logic [`MRSM_EVT_W-1:0] next_mask;
    logic [1:0] next_control;
    logic [31:0] next_avsReaddata;
    logic [`MRSM_EVT_W-1:0] events;
    logic writeTaken;

    function automatic logic regHit(input logic [`MRSM_ADDR_W-1:0] addr,
                                    input logic [`MRSM_ADDR_W-1:0] offset);
        regHit = (addr == offset);
    endfunction

    // one wait cycle per access keeps read data registered
    assign avsWaitrequest = (avsRead | avsWrite) & ~ack;
    assign writeTaken = avsWrite & ack;

    always_comb begin
        events = '0;
        events[`MRSM_EVT_STRAP] = strapEvent;
        events[`MRSM_EVT_RXERR] = rxClkFall & rxFrameActive & rxErrDetect & ~symbolMode;
        events[`MRSM_EVT_TXERR] = txErrActive;
    end

    always_comb begin
        next_ack = (avsRead | avsWrite) & ~ack;
        next_status = status;
        next_mask = mask;
        next_control = control;
        next_avsReaddata = avsReaddata;
        if (writeTaken && regHit(avsAddress, `MRSM_REG_STATUS)) begin
            next_status = status & ~avsWritedata[`MRSM_EVT_W-1:0];
        end
        if (writeTaken && regHit(avsAddress, `MRSM_REG_MASK)) begin
            next_mask = avsWritedata[`MRSM_EVT_W-1:0];
        end
        if (writeTaken && regHit(avsAddress, `MRSM_REG_CONTROL)) begin
            next_control = avsWritedata[1:0];
        end
        // a new event beats a clear in the same cycle
        next_status = next_status | events;
        if (avsRead && !ack) begin
            next_avsReaddata = 32'h0;
            if (regHit(avsAddress, `MRSM_REG_STATUS)) begin
                next_avsReaddata[`MRSM_EVT_W-1:0] = status;
            end else if (regHit(avsAddress, `MRSM_REG_MASK)) begin
                next_avsReaddata[`MRSM_EVT_W-1:0] = mask;
            end else if (regHit(avsAddress, `MRSM_REG_STRAPS)) begin
                next_avsReaddata[2:0] = modeStrap;
                next_avsReaddata[`MRSM_STRAP_IRQSEL] = irqPinSelectStrap;
                next_avsReaddata[`MRSM_STRAP_RMII] = rmiiMode;
                next_avsReaddata[`MRSM_STRAP_DONE] = strapDone;
            end else if (regHit(avsAddress, `MRSM_REG_CONTROL)) begin
                next_avsReaddata[1:0] = control;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ack <= 1'b0;
            status <= '0;
            mask <= `MRSM_MASK_RESET;
            control <= `MRSM_CTRL_RESET;
            avsReaddata <= 32'h0;
        end else begin
            ack <= next_ack;
            status <= next_status;
            mask <= next_mask;
            control <= next_control;
            avsReaddata <= next_avsReaddata;
        end
    end

    // level interrupt, also drives the shared pin when selected
    assign irq = |(status & mask);
endmodule

// >>> hw/mrsm_sync.sv
// two flip-flop level synchroniser, one bit per lane
// assumes its inputs are asynchronous to clk_sys
`timescale 1ns/100ps
module mrsm_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async,
    output logic [WIDTH-1:0] synced
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= '0;
            synced <= '0;
        end else begin
            stage1 <= async;
            synced <= stage1;
        end
    end
endmodule

// >>> include/mrsm_params.svh
// constants for the receive pin mux and strap capture block
// assumes a 25 MHz system clock and an Avalon-MM register slave
//
// Summary of operation
// - In MII mode each received nibble leaves on four data pins, index 0 the least significant bit.
// - Receive data pins 0 to 2 are sampled as the three-bit default operating mode strap.
// - In RMII mode receive data bits 2 and 3 are unused and only the low two carry data.
// - At reset release receive data pin 3 is sampled to pick the role of the shared pin.
// - A high or floating select strap makes the shared pin the active-low interrupt output.
// - A low select strap makes the shared pin the transmit error or symbol bit 4 input.
// - The receive error pin is asserted when an error is found in the frame being sent out.
// - In symbol mode the receive error pin carries bit 4 of the received five-bit group.
// - The MII or RMII selection is latched from its strap pin as internal reset ends.
// - Transmit error replaces the encoded word with the error group, ignored at 10 Mb/s.
`ifndef MRSM_PARAMS_SVH
`define MRSM_PARAMS_SVH

// -----------------------------------------------------------------
// register map, byte addresses
// -----------------------------------------------------------------
`define MRSM_ADDR_W 4
`define MRSM_REG_STATUS 4'h0
`define MRSM_REG_MASK 4'h4
`define MRSM_REG_STRAPS 4'h8
`define MRSM_REG_CONTROL 4'hc

// -----------------------------------------------------------------
// status and mask bit positions
// -----------------------------------------------------------------
`define MRSM_EVT_W 3
`define MRSM_EVT_STRAP 0
`define MRSM_EVT_RXERR 1
`define MRSM_EVT_TXERR 2

// -----------------------------------------------------------------
// strap register fields, control fields
// -----------------------------------------------------------------
`define MRSM_STRAP_MODE_LSB 0
`define MRSM_STRAP_IRQSEL 3
`define MRSM_STRAP_RMII 4
`define MRSM_STRAP_DONE 5
`define MRSM_CTRL_SYMBOL 0
`define MRSM_CTRL_SPEED10 1

// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define MRSM_MASK_RESET 3'h0
`define MRSM_CTRL_RESET 2'h0
`define MRSM_TX_ERROR_GROUP 5'h04
`define MRSM_SYNC_STAGES 2
`define MRSM_SETTLE_CYCLES 3'h3

`endif

// >>> include/mrsm_pkg.sv
// types shared by the receive pin mux block
// assumes mrsm_params.svh supplies the numeric constants
package mrsm_pkg;
    // strap capture sequence after reset release
    typedef enum logic [1:0] {
        STRAP_SETTLE,
        STRAP_CAPTURE,
        STRAP_RUN
    } mrsm_strap_state_t;

    typedef logic [2:0] mrsm_mode_t;
endpackage

// >>> test/mrsm_mac_model.sv
// mac side of the receive pins: strap resistors, rx clock, tx error
// assumes the bench picks strap levels and when frames run
`timescale 1ns/100ps
module mrsm_mac_model (
    input wire logic rxRun,
    input wire logic [2:0] strapMode,
    input wire logic strapSel,
    input wire logic strapRmii,
    input wire logic txErrDrive,
    input wire logic [3:0] rxdPinOut,
    input wire logic [3:0] rxdPinOe,
    input wire logic rxErrPinOut,
    input wire logic rxErrPinOe,
    input wire logic sharedIrqTxerrPinOut,
    input wire logic sharedIrqTxerrPinOe,
    output logic rxClkPin,
    output logic [3:0] rxdPinIn,
    output logic rmiiStrapPin,
    output logic sharedIrqTxerrPinIn,
    output logic rxErrLine
);
    // 320 ns clock, idle high; odd offset keeps edges off clk_sys
    initial begin
        rxClkPin = 1'b1;
        #7;
        forever begin
            #160;
            rxClkPin = rxRun ? ~rxClkPin : 1'b1;
        end
    end
    // strap resistors win wherever the device lets go
    assign rxdPinIn = (rxdPinOe & rxdPinOut)
        | (~rxdPinOe & {strapSel, strapMode});
    assign rmiiStrapPin = strapRmii;
    // pull-down on the error line; in rmii the mac ignores it
    assign rxErrLine = rxErrPinOe ? rxErrPinOut : 1'b0;
    // pull-up in interrupt role, mac drives it in tx error role
    assign sharedIrqTxerrPinIn = sharedIrqTxerrPinOe ? sharedIrqTxerrPinOut
        : (strapSel | txErrDrive);
endmodule

// >>> test/mrsm_pin_mux_properties.sv
// port assertions for the receive pin mux
// assumes one clk_sys domain and bind into mrsm_pin_mux
`timescale 1ns/100ps
module mrsm_pin_mux_properties
    import mrsm_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic irq,
    input wire logic [3:0] rxdPinOut,
    input wire logic [3:0] rxdPinOe,
    input wire logic rxErrPinOut,
    input wire logic rxErrPinOe,
    input wire logic sharedIrqTxerrPinOut,
    input wire logic sharedIrqTxerrPinOe,
    input wire logic [4:0] txCodeIn,
    input wire logic [4:0] txCodeOut,
    input wire mrsm_mode_t modeStrap,
    input wire logic rmiiMode,
    input wire logic irqPinSelectStrap
);
    logic [3:0] relCnt;
    logic [3:0] next_relCnt;
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // cycles since release, saturates so it never wraps back into range
    always_comb begin
        next_relCnt = (relCnt == 4'hf) ? relCnt : relCnt + 4'h1;
    end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            relCnt <= 4'h0;
        end else begin
            relCnt <= next_relCnt;
        end
    end
    // -----------------------------------------------------------------
    // properties
    // -----------------------------------------------------------------
    rmii_lanes_a: assert property (rmiiMode |->
        rxdPinOe[3:2] == 2'h0 && rxdPinOut[3:2] == 2'h0)
        else $error("upper lanes active in rmii");
    pins_quiet_a: assert property (!rxErrPinOe |->
        rxdPinOe == 4'h0 && rxdPinOut == 4'h0 && !rxErrPinOut)
        else $error("pins driven before capture");
    straps_hold_a: assert property (rxErrPinOe |=>
        $stable({modeStrap, rmiiMode, irqPinSelectStrap}))
        else $error("strap changed after capture");
    capture_late_a: assert property (rxErrPinOe |-> relCnt >= 4'h3)
        else $error("capture too early");
    capture_due_a: assert property (relCnt >= 4'ha |-> rxErrPinOe)
        else $error("capture never done");
    irq_role_a: assert property (sharedIrqTxerrPinOe |->
        irqPinSelectStrap && !sharedIrqTxerrPinOut)
        else $error("shared pin driven wrongly");
    irq_drive_a: assert property (irq && irqPinSelectStrap |->
        ##[0:2] sharedIrqTxerrPinOe)
        else $error("interrupt not shown");
    tx_pass_a: assert property (irqPinSelectStrap && $past(rxErrPinOe) |->
        txCodeOut == $past(txCodeIn))
        else $error("tx word altered");
endmodule
bind mrsm_pin_mux mrsm_pin_mux_properties chk_i (.clk_sys, .rst_n, .irq, .rxdPinOut, .rxdPinOe,
    .rxErrPinOut, .rxErrPinOe, .sharedIrqTxerrPinOut, .sharedIrqTxerrPinOe, .txCodeIn,
    .txCodeOut, .modeStrap, .rmiiMode, .irqPinSelectStrap);

// >>> test/mrsm_pin_mux_tb.sv
// self-checking bench for the receive pin mux
// assumes the mac model supplies straps and the receive clock
`timescale 1ns/100ps
module mrsm_pin_mux_tb
    import mrsm_pkg::*;
;
    logic clk_sys, rst_n, avsRead, avsWrite, avsWaitrequest, irq, rxClkPin, rxErrLine;
    logic rxFrameActive, rxErrDetect, rxErrPinOut, rxErrPinOe, rmiiStrapPin, rmiiMode;
    logic sharedIrqTxerrPinIn, sharedIrqTxerrPinOut, sharedIrqTxerrPinOe, irqPinSelectStrap;
    logic strapSel, strapRmii, txErrDrive, rxRun;
    logic [2:0] strapMode;
    logic [3:0] avsAddress, rxNibble, rxdPinIn, rxdPinOut, rxdPinOe;
    logic [4:0] rxSymbol, txCodeIn, txCodeOut;
    logic [31:0] avsWritedata, avsReaddata, rd;
    logic [9:0] r;
    mrsm_mode_t modeStrap;
    int failures = 0;
    int comparisons = 0;
    // rows: mode, irq select, rmii, nibble, error
    logic [9:0] rows [8] = '{10'b000_1_0_1010_1, 10'b001_0_0_0101_0, 10'b010_1_1_1111_1,
        10'b011_0_1_0110_0, 10'b100_1_0_1001_0, 10'b101_0_0_0011_1, 10'b110_1_1_1100_0,
        10'b111_0_0_1110_1};
    mrsm_pin_mux DUT (.clk_sys, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
        .avsReaddata, .avsWaitrequest, .irq, .rxClkPin, .rxNibble, .rxSymbol, .rxFrameActive,
        .rxErrDetect, .rxdPinIn, .rxdPinOut, .rxdPinOe, .rxErrPinOut, .rxErrPinOe, .rmiiStrapPin,
        .sharedIrqTxerrPinIn, .sharedIrqTxerrPinOut, .sharedIrqTxerrPinOe, .txCodeIn, .txCodeOut,
        .modeStrap, .rmiiMode, .irqPinSelectStrap);
    mrsm_mac_model mac (.rxRun, .strapMode, .strapSel, .strapRmii, .txErrDrive, .rxdPinOut,
        .rxdPinOe, .rxErrPinOut, .rxErrPinOe, .sharedIrqTxerrPinOut, .sharedIrqTxerrPinOe,
        .rxClkPin, .rxdPinIn, .rmiiStrapPin, .sharedIrqTxerrPinIn, .rxErrLine);
    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;
    // -----------------------------------------------------------------
    // tasks
    // -----------------------------------------------------------------
    task tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one avalon access, held until waitrequest is seen low
    task avXfer(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] q);
        int n;
        @(posedge clk_sys);
        avsAddress <= a;
        avsWritedata <= wd;
        avsWrite <= wr;
        avsRead <= ~wr;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avsWaitrequest !== 1'b0 && n < 40);
        if (n >= 40) failures++;
        q = avsReaddata;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
    endtask
    // reset with the given straps; pins must stay released meanwhile
    task doReset(input logic [2:0] m, input logic s, input logic rm);
        strapMode <= m;
        strapSel <= s;
        strapRmii <= rm;
        txErrDrive <= 1'b0;
        rst_n <= 1'b0;
        tick(8);
        chk(rxdPinOe, 4'h0);
        chk(rxErrLine, 1'b0);
        rst_n <= 1'b1;
        tick(12);
    endtask
    // a short frame: the rx clock only runs inside it
    task rxBurst;
        rxRun <= 1'b1;
        tick(20);
        rxRun <= 1'b0;
        tick(8);
    endtask
    task tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // watchdog, far beyond the expected 540 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        failures++;
        tally_and_finish;
    end
    // -----------------------------------------------------------------
    // main sequence
    // -----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        {rst_n, avsRead, avsWrite, rxFrameActive, rxErrDetect, txErrDrive, rxRun} = '0;
        {avsAddress, avsWritedata, rxNibble, rxSymbol, txCodeIn} = '0;
        {strapMode, strapSel, strapRmii} = 5'h08;
        @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            r = rows[i];
            doReset(r[9:7], r[6], r[5]);
            chk(modeStrap, r[9:7]);
            chk(irqPinSelectStrap, r[6]);
            chk(rmiiMode, r[5]);
            avXfer(1'b0, 4'h8, 32'h0, rd);
            chk(rd, {26'h0, 1'b1, r[5], r[6], r[9:7]});
            rxNibble <= r[4:1];
            txCodeIn <= {1'b0, r[4:1]};
            rxErrDetect <= r[0];
            rxFrameActive <= 1'b1;
            rxBurst;
            chk(rxdPinOut, r[5] ? {2'b00, r[2:1]} : r[4:1]);
            chk(rxdPinOe, r[5] ? 4'h3 : 4'hf);
            chk(rxErrPinOut, r[0]);
            // frame error leaves a sticky mark beside the capture mark
            avXfer(1'b0, 4'h0, 32'h0, rd);
            chk(rd, {29'h0, 1'b0, r[0], 1'b1});
        end
        // interrupt role: raise, mask, clear; unmapped and read-only places
        doReset(3'h0, 1'b1, 1'b0);
        avXfer(1'b0, 4'h0, 32'h0, rd);
        chk(rd[0], 1'b1);
        chk(irq, 1'b0);
        avXfer(1'b1, 4'h4, 32'h1, rd);
        tick(2);
        chk({irq, sharedIrqTxerrPinOe}, 2'b11);
        avXfer(1'b1, 4'h0, 32'h1, rd);
        tick(2);
        chk({irq, sharedIrqTxerrPinOe}, 2'b00);
        avXfer(1'b0, 4'h1, 32'h0, rd);
        chk(rd, 32'h0);
        avXfer(1'b1, 4'h8, 32'hffffffff, rd);
        avXfer(1'b0, 4'h8, 32'h0, rd);
        chk(rd, 32'h28);
        // transmit error role: the pin becomes an input
        doReset(3'h5, 1'b0, 1'b0);
        txErrDrive <= 1'b1;
        txCodeIn <= 5'h0a;
        avXfer(1'b1, 4'h4, 32'h7, rd);
        tick(4);
        chk({irq, sharedIrqTxerrPinOe}, 2'b10);
        chk(txCodeOut, 5'h04);
        avXfer(1'b1, 4'hc, 32'h2, rd);
        tick(2);
        chk(txCodeOut, 5'h0a);
        avXfer(1'b1, 4'hc, 32'h1, rd);
        tick(2);
        chk(txCodeOut, 5'h1a);
        rxSymbol <= 5'h13;
        rxBurst;
        chk({rxErrPinOut, rxdPinOut}, 5'h13);
        tally_and_finish;
    end
endmodule
